// ==== rtl/prescale_if.sv ====
// Interface between the timer core and its prescaler.
interface prescale_if;
	import reload_timer_pkg::*;

	clk_sel_t sel;
	logic     tick;

	modport core (output sel, input tick);
	modport presc (input sel, output tick);
endinterface

// ==== rtl/reload_interval_timer8.sv ====
// Eight-bit interval and auto-reload timer with an APB register slave and one interrupt.
//
// The implementer's own choices: the APB register port and the placing of the registers.
module reload_interval_timer8
	import reload_timer_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              event_in,
	input  wire logic              event_edge_sel,
	input  wire logic              event_pin_func,
	output logic                   irq
);

	typedef struct packed {
		logic              reload_mode_sel;
		clk_sel_t          clk_sel;
		logic [DATA_W-1:0] count;
		logic [DATA_W-1:0] reload;
		logic              overflow_irq_flag;
		logic              overflow_irq_enable;
		logic              ev_sync1;
		logic              ev_sync2;
		logic              ev_prev;
		logic [31:0]       rdata;
		logic              ready;
		logic              slverr;
		logic              irq;
	} timer_state_t;

	timer_state_t s_q;
	timer_state_t s_d;

	prescale_if ps ();

	timer_prescaler u_prescaler (
		.pclk    (pclk),
		.presetn (presetn),
		.ps      (ps)
	);

	assign ps.sel = s_q.clk_sel;

	logic setup_phase;
	logic access_wr;
	logic event_level;
	logic event_edge;
	logic count_pulse;
	logic overflow;
	logic reload_wr;
	logic mode_wr;
	logic clear_wr;
	logic enable_wr;
	logic mapped;

	// Decodes whether an address belongs to the register map.
	function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
		return (a == ADDR_MODE) || (a == ADDR_COUNT) || (a == ADDR_IRQ_STAT) ||
			(a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_EN);
	endfunction

	// Builds the word that a read of an address returns, from the current state.
	function automatic logic [31:0] read_word(input logic [APB_AW-1:0] a,
		input timer_state_t st);
		logic [31:0] w;
		w = '0;
		case (a)
			ADDR_MODE: begin
				w[MODE_SEL_BIT]             = st.reload_mode_sel;
				w[MODE_SEL_BIT-1:CLK_SEL_MSB+1] = MODE_RSVD;
				w[CLK_SEL_MSB:CLK_SEL_LSB]  = st.clk_sel;
			end
			ADDR_COUNT: begin
				// The live count is returned; the reload value is never visible.
				w[DATA_W-1:0] = st.count;
			end
			ADDR_IRQ_STAT: begin
				w[IRQ_OVF_BIT] = st.overflow_irq_flag;
			end
			ADDR_IRQ_EN: begin
				w[IRQ_OVF_BIT] = st.overflow_irq_enable;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction

	// The next count after one pulse: step up, or leave ff for zero or the reload value.
	function automatic logic [DATA_W-1:0] next_count(input logic [DATA_W-1:0] c,
		input logic auto_mode, input logic [DATA_W-1:0] rl);
		logic [DATA_W-1:0] n;
		if (c == COUNT_TOP) begin
			if (auto_mode) begin
				n = rl;
			end else begin
				n = COUNT_WRAP;
			end
		end else begin
			n = c + DATA_W'(1);
		end
		return n;
	endfunction

	always_comb begin
		setup_phase = psel && !penable;
		access_wr   = psel && penable && pwrite && s_q.ready;
		mapped      = addr_mapped(paddr);
		mode_wr     = access_wr && (paddr == ADDR_MODE);
		reload_wr   = access_wr && (paddr == ADDR_COUNT);
		clear_wr    = access_wr && (paddr == ADDR_IRQ_CLEAR);
		enable_wr   = access_wr && (paddr == ADDR_IRQ_EN);
	end

	// A pin that is not routed to the timer reads as low, so no edges are seen.
	always_comb begin
		event_level = event_in && event_pin_func;
	end

	// Edges are detected on the second and third flops only; the first one is a bare sync stage.
	always_comb begin
		if (event_edge_sel) begin
			event_edge = s_q.ev_sync2 && !s_q.ev_prev;
		end else begin
			event_edge = !s_q.ev_sync2 && s_q.ev_prev;
		end
	end

	always_comb begin
		if (s_q.clk_sel == SEL_EVENT) begin
			count_pulse = event_edge;
		end else begin
			count_pulse = ps.tick;
		end
		overflow = count_pulse && (s_q.count == COUNT_TOP) && !reload_wr;
	end

	always_comb begin
		s_d = s_q;

		s_d.ev_sync1 = event_level;
		s_d.ev_sync2 = s_q.ev_sync1;
		s_d.ev_prev  = s_q.ev_sync2;

		// Counting never waits for a start bit; it runs from reset onward.
		if (reload_wr) begin
			// A software load overrides a pulse in the same cycle, so no count is lost twice.
			s_d.reload = pwdata[DATA_W-1:0];
			s_d.count  = pwdata[DATA_W-1:0];
		end else if (count_pulse) begin
			s_d.count = next_count(s_q.count, s_q.reload_mode_sel, s_q.reload);
		end

		if (mode_wr) begin
			s_d.reload_mode_sel = pwdata[MODE_SEL_BIT];
			s_d.clk_sel         = clk_sel_t'(pwdata[CLK_SEL_MSB:CLK_SEL_LSB]);
		end

		if (enable_wr) begin
			s_d.overflow_irq_enable = pwdata[IRQ_OVF_BIT];
		end

		// A new overflow in the clearing cycle keeps the flag set.
		if (clear_wr && pwdata[IRQ_OVF_BIT]) begin
			s_d.overflow_irq_flag = 1'b0;
		end
		if (overflow) begin
			s_d.overflow_irq_flag = 1'b1;
		end

		s_d.irq = s_d.overflow_irq_flag && s_d.overflow_irq_enable;

		// The answer is prepared in the setup cycle, so every access phase is one cycle long.
		s_d.ready  = setup_phase;
		s_d.slverr = setup_phase && !mapped;
		if (setup_phase && !pwrite) begin
			s_d.rdata = read_word(paddr, s_q);
		end else if (!psel) begin
			s_d.rdata = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.reload_mode_sel     <= 1'b0;
			s_q.clk_sel             <= CLK_SEL_RESET;
			s_q.count               <= COUNT_RESET;
			s_q.reload              <= RELOAD_RESET;
			s_q.overflow_irq_flag   <= 1'b0;
			s_q.overflow_irq_enable <= 1'b0;
			s_q.ev_sync1            <= 1'b0;
			s_q.ev_sync2            <= 1'b0;
			s_q.ev_prev             <= 1'b0;
			s_q.rdata               <= '0;
			s_q.ready               <= 1'b0;
			s_q.slverr              <= 1'b0;
			s_q.irq                 <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.rdata;
	assign pready  = s_q.ready;
	assign pslverr = s_q.slverr;
	assign irq     = s_q.irq;

endmodule

// ==== rtl/reload_timer_pkg.sv ====
// Package of constants, register map and types for the reload interval timer.
// Notes on behaviour
// - The counter is eight bits wide and steps up by one on every pulse of the chosen count source.
// - Mode bit 7 of timer_mode selects interval operation at 0 and auto-reload operation at 1.
// - Bits 6 to 3 of timer_mode are reserved and always read back as ones, whatever is written.
// - Clock-select codes 000 to 110 pick the system clock divided by 8192, 2048, 512, 256, 64, 16, 4.
// - Clock-select code 111 counts edges of event_in, with the edge chosen by event_edge_sel.
// - Counter and reload share one address; a read returns the live count, a write stores the reload.
// - The counter is loaded by every reload write and may be read at any time without disturbing it.
// - A count pulse arriving while the counter holds ff sets overflow_irq_flag, unless a reload write comes in the same cycle.
// - The interrupt reaches the processor only while overflow_irq_enable is set, in both modes.
// - In interval mode the counter wraps to 00 on overflow and keeps counting up.
// - Writing a reload value also loads it into the counter at once, in either mode.
// - In auto-reload mode each overflow loads the stored reload value instead of zero.
// - The auto-reload overflow period is 256 minus the reload value, from 1 to 256 pulses.
// - Reset clears counter, reload and mode bit, and interval counting starts with no start control.
// - The reload register is eight bits, write-only, and cannot be read back.
package reload_timer_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PRESC_W       = 13;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned APB_AW        = 12;

	// Byte addresses on the APB.
	localparam logic [APB_AW-1:0] ADDR_MODE      = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_COUNT     = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_IRQ_STAT  = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_IRQ_CLEAR = 12'h00c;
	localparam logic [APB_AW-1:0] ADDR_IRQ_EN    = 12'h010;

	// Field positions of timer_mode.
	localparam int unsigned MODE_SEL_BIT = 7;
	localparam int unsigned CLK_SEL_MSB  = 2;
	localparam int unsigned CLK_SEL_LSB  = 0;
	localparam logic [3:0]  MODE_RSVD    = 4'hf;

	// Bit of the overflow event in the status, clear and enable registers.
	localparam int unsigned IRQ_OVF_BIT = 0;

	localparam logic [DATA_W-1:0] COUNT_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] RELOAD_RESET = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_TOP    = 8'hff;
	localparam logic [DATA_W-1:0] COUNT_WRAP   = 8'h00;

	typedef enum logic [2:0] {
		SEL_DIV8192,
		SEL_DIV2048,
		SEL_DIV512,
		SEL_DIV256,
		SEL_DIV64,
		SEL_DIV16,
		SEL_DIV4,
		SEL_EVENT
	} clk_sel_t;

	localparam clk_sel_t CLK_SEL_RESET = SEL_DIV8192;

	// Divide ratio of each internal source, in system clock cycles per pulse.
	localparam int unsigned DIV_8192 = 8192;
	localparam int unsigned DIV_2048 = 2048;
	localparam int unsigned DIV_512  = 512;
	localparam int unsigned DIV_256  = 256;
	localparam int unsigned DIV_64   = 64;
	localparam int unsigned DIV_16   = 16;
	localparam int unsigned DIV_4    = 4;

endpackage

// ==== rtl/timer_prescaler.sv ====
// Free-running prescaler that yields a one-cycle count enable for the selected divide ratio.
module timer_prescaler
	import reload_timer_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	prescale_if.presc ps
);

	typedef struct packed {
		logic [PRESC_W-1:0] div;
	} presc_state_t;

	presc_state_t s_q;
	presc_state_t s_d;

	// A tap pulses once every 2^k cycles, when the low k bits of the divider are all ones.
	function automatic logic tap(input logic [PRESC_W-1:0] d, input int unsigned ratio);
		logic [PRESC_W-1:0] m;
		m = PRESC_W'(ratio - 1);
		return (d & m) == m;
	endfunction

	always_comb begin
		s_d     = s_q;
		s_d.div = s_q.div + PRESC_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// The tap changes with the selection, so a switch may shorten the first period.
	always_comb begin
		case (ps.sel)
			SEL_DIV8192: ps.tick = tap(s_q.div, DIV_8192);
			SEL_DIV2048: ps.tick = tap(s_q.div, DIV_2048);
			SEL_DIV512:  ps.tick = tap(s_q.div, DIV_512);
			SEL_DIV256:  ps.tick = tap(s_q.div, DIV_256);
			SEL_DIV64:   ps.tick = tap(s_q.div, DIV_64);
			SEL_DIV16:   ps.tick = tap(s_q.div, DIV_16);
			SEL_DIV4:    ps.tick = tap(s_q.div, DIV_4);
			default:     ps.tick = 1'b0;
		endcase
	end

endmodule

// ==== sim/reload_interval_timer8_properties.sv ====
// Concurrent checks on the timer's APB port and interrupt line.
module reload_interval_timer8_properties
	import reload_timer_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_in_access: assert property (pready |-> psel && penable && !$past(penable))
		else $error("ready outside access");
	chk_mode_rsvd_ones: assert property (pready && !pwrite && paddr == ADDR_MODE |->
		prdata[6:3] == MODE_RSVD && prdata[31:8] == 24'h0)
		else $error("reserved mode bits wrong");
	chk_count_eight_bits: assert property (pready && !pwrite && paddr == ADDR_COUNT |->
		prdata[31:8] == 24'h0)
		else $error("count wider than eight bits");
	chk_bad_addr_err: assert property (psel && !penable && paddr > ADDR_IRQ_EN |=>
		pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_good_addr_ok: assert property (psel && !penable && paddr <= ADDR_IRQ_EN &&
		paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	chk_irq_masked: assert property (pready && pwrite && paddr == ADDR_IRQ_EN &&
		!pwdata[0] |=> !irq)
		else $error("irq high while masked");
	chk_irq_has_flag: assert property (pready && !pwrite && paddr == ADDR_IRQ_STAT &&
		$past(irq) |-> prdata[0])
		else $error("irq without flag");
	// Read data is registered, so it returns to zero one cycle after the bus goes idle.
	chk_idle_read_zero: assert property (!$past(psel) |-> prdata == 32'h0)
		else $error("read data outside transfer");
	cover property ($rose(irq));
	cover property (pready && pslverr);
	cover property (pready && pwrite && paddr == ADDR_MODE && pwdata[7]);
endmodule

bind reload_interval_timer8 reload_interval_timer8_properties i_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ==== sim/tb_reload_interval_timer8.sv ====
// Self-checking bench for the eight-bit interval and auto-reload timer.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module tb_reload_interval_timer8 import reload_timer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              pclk, presetn, psel, penable, pwrite, rerr;
	logic              event_in, event_edge_sel, event_pin_func, pready, pslverr, irq;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata, prdata, rdat;
	logic [7:0]        mode;
	int                miscompares, n_checks, cyc, cnt, rld, flag, i, r;
	int                dv[7] = '{DIV_8192, DIV_2048, DIV_512, DIV_256, DIV_64, DIV_16, DIV_4};

	reload_interval_timer8 i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
		.event_edge_sel(event_edge_sel), .event_pin_func(event_pin_func), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			miscompares++;
			wrap_up();
		end
	end

	// The request stays put until ready is seen at a rising edge.
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		`CHK(k, 1)
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdat, e)
		`CHK(rerr, 1'b0)
	endtask

	// Each pulse gives exactly one edge of the selected polarity.
	task automatic pulse(input int n);
		repeat (n) begin
			event_in <= event_edge_sel;
			repeat (6) @(posedge pclk);
			event_in <= ~event_edge_sel;
			repeat (6) @(posedge pclk);
			if (cnt == 255) begin
				cnt = mode[7] ? rld : 0;
				flag = 1;
			end else
				cnt++;
		end
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, event_in, event_edge_sel} = '0;
		{event_pin_func, presetn, cnt, flag, miscompares, n_checks} = '0;
		r = $urandom(32'h2276cd9f);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_MODE, 32'h78);
		rd(ADDR_COUNT, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h0);
		rd(ADDR_IRQ_EN, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		`CHK({rerr, rdat}, 33'h100000000)
		for (i = 0; i < 7; i++) begin
			r = $urandom;
			apb(1'b1, ADDR_MODE, {r[31:8], 1'b0, r[6:3], 3'(i)});
			rd(ADDR_MODE, {24'h0, 5'h0f, 3'(i)});
			apb(1'b1, ADDR_COUNT, 32'h0);
			repeat (2 * dv[i]) @(posedge pclk);
			apb(1'b0, ADDR_COUNT, 32'h0);
			`CHK(rdat >= 2 && rdat <= 3, 1'b1)
		end
		event_pin_func <= 1'b1;
		for (i = 0; i < 4; i++) begin
			event_edge_sel <= i[0];
			event_in <= ~i[0];
			mode = {i[1], 7'h7f};
			apb(1'b1, ADDR_MODE, {24'h0, mode});
			rd(ADDR_MODE, {24'h0, mode});
			apb(1'b1, ADDR_IRQ_EN, 32'(i[0]));
			rld = (i == 3) ? 255 : (i == 2) ? $urandom_range(254, 1) : 254;
			cnt = rld;
			apb(1'b1, ADDR_COUNT, 32'(rld));
			rd(ADDR_COUNT, 32'(cnt));
			rd(ADDR_COUNT, 32'(cnt));
			pulse(255 - rld);
			rd(ADDR_IRQ_STAT, 32'h0);
			pulse(1);
			rd(ADDR_COUNT, 32'(cnt));
			rd(ADDR_IRQ_STAT, 32'(flag));
			@(negedge pclk);
			`CHK(irq, i[0])
			apb(1'b1, ADDR_IRQ_CLEAR, 32'h1);
			flag = 0;
			rd(ADDR_IRQ_STAT, 32'(flag));
			@(negedge pclk);
			`CHK(irq, 1'b0)
		end
		wrap_up();
	end
endmodule
